// >>> common/sdma_pkg.sv
// constants and types shared by the serial dma status block
package sdma_pkg;
    localparam int FIELD_W = 14;
    localparam int SYNC_STAGES = 2;
    // register byte addresses
    localparam logic [31:0] TX_A_START_OFS = 32'h4000C810;
    localparam logic [31:0] STATUS_OFS = 32'h4000C82C;
    // upper address bits that the transmit buffer a start address register reads back
    localparam logic [31:0] RAM_BASE = 32'h20000000;
    localparam logic [13:0] TX_A_START_RST = 14'h0000;
    localparam logic [31:0] STATUS_RST = 32'h00000000;
    // status field positions
    localparam int SAVE_LSB = 10;
    localparam int FRM_B_BIT = 9;
    localparam int FRM_A_BIT = 8;
    localparam int PAR_B_BIT = 7;
    localparam int PAR_A_BIT = 6;
    localparam int OVF_B_BIT = 5;
    localparam int OVF_A_BIT = 4;
    localparam int TX_B_BIT = 3;
    localparam int TX_A_BIT = 2;
    localparam int RX_B_BIT = 1;
    localparam int RX_A_BIT = 0;
    // count-save status codes
    localparam logic [2:0] SAVE_NONE = 3'h0;
    localparam logic [2:0] SAVE_A_ONCE = 3'h2;
    localparam logic [2:0] SAVE_B_ONCE = 3'h3;
    localparam logic [2:0] SAVE_A_MULTI = 3'h6;
    localparam logic [2:0] SAVE_B_MULTI = 3'h7;
    // ping-pong buffer usage, gray along idle -> a -> b
    typedef enum logic [1:0] {
        BUF_IDLE = 2'h0,
        BUF_A = 2'h1,
        BUF_B = 2'h3
    } buf_state_t;
endpackage

// >>> common/buf_pair_if.sv
// link between the status block and one ping-pong buffer pair engine
`timescale 1ns/1ps
interface buf_pair_if;
    import sdma_pkg::*;
    logic load_a;
    logic load_b;
    logic dma_reset;
    logic [FIELD_W-1:0] start_a;
    logic [FIELD_W-1:0] start_b;
    logic [FIELD_W-1:0] end_a;
    logic [FIELD_W-1:0] end_b;
    logic [FIELD_W-1:0] count_a;
    logic [FIELD_W-1:0] count_b;
    logic loaded_a;
    logic loaded_b;
    logic active_a;
    logic active_b;
    logic unload_a;
    logic unload_b;
    modport engine(
        input load_a, load_b, dma_reset, start_a, start_b, end_a, end_b, count_a, count_b,
        output loaded_a, loaded_b, active_a, active_b, unload_a, unload_b
    );
    modport user(
        output load_a, load_b, dma_reset, start_a, start_b, end_a, end_b, count_a, count_b,
        input loaded_a, loaded_b, active_a, active_b, unload_a, unload_b
    );
endinterface

// >>> core/buf_pair_engine.sv
// ping-pong buffer selection: load, activate, unload
`timescale 1ns/1ps
module buf_pair_engine
    import sdma_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    buf_pair_if.engine bp
);
    buf_state_t state;
    buf_state_t next_state;
    logic loaded_a;
    logic loaded_b;

    // true once start plus count has run past the inclusive end address
    function automatic logic past_end(input logic [FIELD_W-1:0] start, input logic [FIELD_W-1:0] count,
                                      input logic [FIELD_W-1:0] last);
        logic [FIELD_W:0] sum;
        sum = {1'b0, start} + {1'b0, count};
        return sum > {1'b0, last};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // unload past end
    assign bp.unload_a = (state == BUF_A) && past_end(bp.start_a, bp.count_a, bp.end_a);
    assign bp.unload_b = (state == BUF_B) && past_end(bp.start_b, bp.count_b, bp.end_b);
    assign bp.active_a = (state == BUF_A);
    assign bp.active_b = (state == BUF_B);
    assign bp.loaded_a = loaded_a;
    assign bp.loaded_b = loaded_b;

    // loaded means pending or active; a fresh load beats an unload
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded_a <= 1'b0;
            loaded_b <= 1'b0;
        end else if (bp.dma_reset) begin
            loaded_a <= 1'b0;
            loaded_b <= 1'b0;
        end else begin
            loaded_a <= bp.load_a | (loaded_a & ~bp.unload_a);
            loaded_b <= bp.load_b | (loaded_b & ~bp.unload_b);
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            BUF_IDLE: begin
                if (loaded_a) begin
                    next_state = BUF_A;
                end else if (loaded_b) begin
                    next_state = BUF_B;
                end
            end
            BUF_A: begin
                if (bp.unload_a) begin
                    next_state = loaded_b ? BUF_B : BUF_IDLE;
                end
            end
            BUF_B: begin
                if (bp.unload_b) begin
                    next_state = loaded_a ? BUF_A : BUF_IDLE;
                end
            end
            default: begin
                next_state = BUF_IDLE;
            end
        endcase
    end

    // active buffer register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= BUF_IDLE;
        end else if (bp.dma_reset) begin
            state <= BUF_IDLE;
        end else begin
            state <= next_state;
        end
    end
endmodule // buf_pair_engine

// >>> core/serial_dma_status.sv
// serial dma status register and transmit buffer a start address
//
// Operation
// - spi slave: record count-save on slave select deassert; clear on rx load/reset
// - save codes: 0 none, 2/3 a/b once, 6/7 a/b more than once
// - first controller uart: per-buffer frame error flag, cleared on load or reset
// - first controller uart: per-buffer parity error flag, cleared on load or reset
// - overflow with no rx buffer loaded goes to next buffer that drains
// - transmit in-use bits show which transmit buffer is active
// - receive in-use bits show which receive buffer is active
// - read-write 14-bit transmit buffer a start address, used when a becomes active
// - loading a and b together uses buffer a first
// - a buffer unloads once start plus count exceeds its end address
//
// two ping-pong engines, one for transmit and one for receive, keep the
// loaded and active state of buffers a and b; this module adds the start
// address register of transmit buffer a, the receive error flags, the
// count-save record and the status word. loads, resets, counts and end
// addresses arrive as ports from the control part of the channel.
// limitation: the fetch address is only computed here; the ram master that
// uses it lives elsewhere.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module serial_dma_status
    import sdma_pkg::*;
#(
    parameter bit FIRST_CTRL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // controller mode
    input wire logic uart_mode,
    input wire logic spi_slave_mode,
    input wire logic slave_select_n,
    // transmit buffer control
    input wire logic tx_load_a,
    input wire logic tx_load_b,
    input wire logic tx_dma_reset,
    input wire logic [FIELD_W-1:0] tx_start_b,
    input wire logic [FIELD_W-1:0] tx_end_a,
    input wire logic [FIELD_W-1:0] tx_end_b,
    input wire logic [FIELD_W-1:0] tx_count,
    // receive buffer control
    input wire logic rx_load_a,
    input wire logic rx_load_b,
    input wire logic rx_dma_reset,
    input wire logic [FIELD_W-1:0] rx_start_a,
    input wire logic [FIELD_W-1:0] rx_start_b,
    input wire logic [FIELD_W-1:0] rx_end_a,
    input wire logic [FIELD_W-1:0] rx_end_b,
    input wire logic [FIELD_W-1:0] rx_count_a,
    input wire logic [FIELD_W-1:0] rx_count_b,
    // receive fifo side
    input wire logic rx_take,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    input wire logic rx_fifo_overflow,
    // transmit fetch address toward ram
    output logic [FIELD_W-1:0] tx_fetch_addr,
    output logic tx_fetch_valid
);
    buf_pair_if tx_bp ();
    buf_pair_if rx_bp ();

    logic [FIELD_W-1:0] tx_a_start_field;
    logic rx_a_frame_err;
    logic rx_b_frame_err;
    logic rx_a_parity_err;
    logic rx_b_parity_err;
    logic rx_a_overrun;
    logic rx_b_overrun;
    logic overrun_pending;
    logic [2:0] count_save_status;
    logic [SYNC_STAGES-1:0] ss_sync;
    logic ss_prev;
    logic ss_deassert;
    logic uart_checks;
    logic take_a;
    logic take_b;
    logic rx_clear_a;
    logic rx_clear_b;
    logic [31:0] status_word;

    // sticky flag update: a set in the same cycle as a clear survives
    // one helper serves every flag so that all of them share one priority
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // buffer pair engines

    assign tx_bp.load_a = tx_load_a;
    assign tx_bp.load_b = tx_load_b;
    assign tx_bp.dma_reset = tx_dma_reset;
    assign tx_bp.start_a = tx_a_start_field;
    assign tx_bp.start_b = tx_start_b;
    assign tx_bp.end_a = tx_end_a;
    assign tx_bp.end_b = tx_end_b;
    // transmit has one count shared by whichever buffer is active
    assign tx_bp.count_a = tx_count;
    assign tx_bp.count_b = tx_count;

    // receive keeps a count per buffer; counts and ends may change while a
    // buffer is active, which can unload it early
    assign rx_bp.load_a = rx_load_a;
    assign rx_bp.load_b = rx_load_b;
    assign rx_bp.dma_reset = rx_dma_reset;
    assign rx_bp.start_a = rx_start_a;
    assign rx_bp.start_b = rx_start_b;
    assign rx_bp.end_a = rx_end_a;
    assign rx_bp.end_b = rx_end_b;
    assign rx_bp.count_a = rx_count_a;
    assign rx_bp.count_b = rx_count_b;

    // both engines run on the system clock and share its reset
    buf_pair_engine tx_engine (
        .clk(clk),
        .nrst(nrst),
        .bp(tx_bp.engine)
    );

    buf_pair_engine rx_engine (
        .clk(clk),
        .nrst(nrst),
        .bp(rx_bp.engine)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer a start address register

    // only the low fourteen bits are stored; the upper address bits are
    // fixed by the ram base and are added back on read
    // start address write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_a_start_field <= TX_A_START_RST;
        end else if (wr && addr == TX_A_START_OFS) begin
            tx_a_start_field <= wdata[FIELD_W-1:0];
        end
    end

    // registered so the ram side sees a clean address, at the cost of one
    // cycle of latency after a buffer turns active
    // fetch from start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_fetch_addr <= '0;
            tx_fetch_valid <= 1'b0;
        end else begin
            tx_fetch_valid <= tx_bp.active_a | tx_bp.active_b;
            if (tx_bp.active_b) begin
                tx_fetch_addr <= tx_start_b + tx_count;
            end else begin
                tx_fetch_addr <= tx_a_start_field + tx_count;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive error flags

    // frame and parity error reporting only exists on the first controller in uart mode
    assign uart_checks = FIRST_CTRL & uart_mode;
    // a byte drained from the fifo belongs to the active buffer
    // a byte taken while no buffer is active has nowhere to report to
    assign take_a = rx_take & rx_bp.active_a;
    assign take_b = rx_take & rx_bp.active_b;
    // a reset clears both buffers' flags, a load only its own buffer's
    assign rx_clear_a = rx_load_a | rx_dma_reset;
    assign rx_clear_b = rx_load_b | rx_dma_reset;

    // sticky, so software still sees the error after the buffer unloads
    // frame error flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_a_frame_err <= 1'b0;
            rx_b_frame_err <= 1'b0;
        end else begin
            rx_a_frame_err <= flag_next(rx_a_frame_err, take_a & rx_frame_err & uart_checks, rx_clear_a);
            rx_b_frame_err <= flag_next(rx_b_frame_err, take_b & rx_frame_err & uart_checks, rx_clear_b);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_a_parity_err <= 1'b0;
            rx_b_parity_err <= 1'b0;
        end else begin
            rx_a_parity_err <= flag_next(rx_a_parity_err, take_a & rx_parity_err & uart_checks, rx_clear_a);
            rx_b_parity_err <= flag_next(rx_b_parity_err, take_b & rx_parity_err & uart_checks, rx_clear_b);
        end
    end

    // overrun held for next buffer
    // an overflow while a buffer is loaded is dropped; nothing here or in the rx engine records it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overrun_pending <= 1'b0;
        end else begin
            overrun_pending <= flag_next(overrun_pending,
                                         rx_fifo_overflow & ~rx_bp.loaded_a & ~rx_bp.loaded_b,
                                         rx_dma_reset | take_a | take_b);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_a_overrun <= 1'b0;
            rx_b_overrun <= 1'b0;
        end else begin
            rx_a_overrun <= flag_next(rx_a_overrun, take_a & overrun_pending, rx_clear_a);
            rx_b_overrun <= flag_next(rx_b_overrun, take_b & overrun_pending, rx_clear_b);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave select deassert detection

    // the pin is asynchronous; only the last stage feeds the edge detector
    // two stages keep metastability away from the detector; the reset value
    // matches the idle deasserted pin so no false edge follows reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_sync <= '1;
            ss_prev <= 1'b1;
        end else begin
            ss_sync <= {ss_sync[SYNC_STAGES-2:0], slave_select_n};
            ss_prev <= ss_sync[SYNC_STAGES-1];
        end
    end

    assign ss_deassert = ss_sync[SYNC_STAGES-1] & ~ss_prev;

    // a deassertion and a buffer load in one cycle: the record wins, so the
    // count that was just saved is not lost to the clear
    // a deassertion while no receive buffer is active saves nothing
    // count save record
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_save_status <= SAVE_NONE;
        end else if (ss_deassert && spi_slave_mode && (rx_bp.active_a || rx_bp.active_b)) begin
            if (count_save_status == SAVE_NONE) begin
                count_save_status <= rx_bp.active_b ? SAVE_B_ONCE : SAVE_A_ONCE;
            end else begin
                count_save_status <= rx_bp.active_b ? SAVE_B_MULTI : SAVE_A_MULTI;
            end
        end else if (rx_load_a || rx_load_b || rx_dma_reset) begin
            count_save_status <= SAVE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word and read port

    // bits above the save field read as zero; the word has no write path
    // at all, which is what keeps it read only
    // transmit in use
    always_comb begin
        status_word = STATUS_RST;
        status_word[SAVE_LSB +: 3] = count_save_status;
        status_word[FRM_B_BIT] = rx_b_frame_err;
        status_word[FRM_A_BIT] = rx_a_frame_err;
        status_word[PAR_B_BIT] = rx_b_parity_err;
        status_word[PAR_A_BIT] = rx_a_parity_err;
        status_word[OVF_B_BIT] = rx_b_overrun;
        status_word[OVF_A_BIT] = rx_a_overrun;
        status_word[TX_B_BIT] = tx_bp.active_b;
        status_word[TX_A_BIT] = tx_bp.active_a;
        status_word[RX_B_BIT] = rx_bp.active_b;
        status_word[RX_A_BIT] = rx_bp.active_a;
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    // holding zero between reads keeps stale status off the bus
    // status is read only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                TX_A_START_OFS: begin
                    rdata <= RAM_BASE | {18'h00000, tx_a_start_field};
                end
                STATUS_OFS: begin
                    rdata <= status_word;
                end
                default: begin
                    rdata <= '0;
                end
            endcase
        end else begin
            rdata <= '0;
        end
    end
endmodule // serial_dma_status

// >>> verif/serial_dma_status_asserts.sv
// assertion checker for the serial dma status block
`timescale 1ns/1ps
module serial_dma_status_asserts
    import sdma_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic slave_select_n,
    input wire logic tx_load_a,
    input wire logic tx_load_b,
    input wire logic tx_dma_reset,
    input wire logic rx_load_a,
    input wire logic rx_load_b,
    input wire logic rx_dma_reset,
    input wire logic rx_take,
    input wire logic tx_fetch_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // bus cycles on the two mapped words
    sequence st_rd; rd && addr == STATUS_OFS; endsequence
    sequence ta_wr; wr && addr == TX_A_START_OFS; endsequence
    sequence ta_rd; rd && addr == TX_A_START_OFS; endsequence
    // pin idle long enough that no count save can race the reset
    sequence rx_quiet_rst; slave_select_n [*6] ##0 (rx_dma_reset && !rx_take && !rx_load_a && !rx_load_b); endsequence
    ////////////////////////////////////////
    rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not idle");
    start_upper_a: assert property (ta_rd |=> rdata[31:14] == RAM_BASE[31:14])
        else $error("start upper bits wrong");
    start_back_a: assert property (ta_wr ##1 ta_rd |=> rdata[13:0] == $past(wdata[13:0], 2))
        else $error("start readback wrong");
    unmapped_rd_a: assert property (rd && addr != STATUS_OFS && addr != TX_A_START_OFS |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    save_code_a: assert property (st_rd |=> !(rdata[12:10] inside {3'h1, 3'h4, 3'h5}))
        else $error("reserved save code");
    in_use_one_a: assert property (st_rd |=> !(&rdata[3:2]) && !(&rdata[1:0]))
        else $error("two buffers in use");
    rx_rst_clear_a: assert property (rx_quiet_rst ##1 st_rd |=> rdata[12:4] == 9'h0 && rdata[1:0] == 2'h0)
        else $error("rx status not cleared");
    tx_rst_idle_a: assert property (tx_dma_reset && !tx_load_a && !tx_load_b |-> ##2 !tx_fetch_valid)
        else $error("tx fetch after reset");
endmodule // serial_dma_status_asserts

bind serial_dma_status serial_dma_status_asserts chk (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .slave_select_n, .tx_load_a, .tx_load_b, .tx_dma_reset, .rx_load_a, .rx_load_b, .rx_dma_reset,
    .rx_take, .tx_fetch_valid);

// >>> verif/rx_fifo_model.sv
// receive fifo model on the far side of the dma
`timescale 1ns/1ps
module rx_fifo_model #(
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic push,
    input wire logic push_fe,
    input wire logic push_pe,
    input wire logic drain_en,
    output logic rx_take,
    output logic rx_frame_err,
    output logic rx_parity_err,
    output logic rx_fifo_overflow
);
    logic [1:0] q[$];
    logic flip;
    // one byte a cycle; error lines toggle when no byte is taken, so they must be qualified
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q.delete();
            flip <= 1'b0;
            {rx_take, rx_frame_err, rx_parity_err, rx_fifo_overflow} <= 4'h0;
        end else begin
            flip <= !flip;
            rx_fifo_overflow <= push && q.size() >= DEPTH;
            rx_take <= drain_en && q.size() > 0;
            if (drain_en && q.size() > 0)
                {rx_frame_err, rx_parity_err} <= q.pop_front();
            else
                {rx_frame_err, rx_parity_err} <= {flip, !flip};
            if (push && q.size() < DEPTH)
                q.push_back({push_fe, push_pe});
        end
    end
endmodule // rx_fifo_model

// >>> verif/tb_top.sv
// self-checking bench for the serial dma status block
`timescale 1ns/1ps
module tb_top
    import sdma_pkg::*;
;
    // pulse masks for {tx rst, tx b, tx a, rx rst, rx b, rx a}
    localparam logic [5:0] RXA = 6'h01, RXB = 6'h02, RXR = 6'h04, TXA = 6'h08, TXB = 6'h10, TXR = 6'h20;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, uart_mode = 1'b1, spi_slave_mode = 1'b0;
    logic slave_select_n = 1'b1, push = 1'b0, push_fe = 1'b0, push_pe = 1'b0, drain_en = 1'b0;
    logic rx_take, rx_frame_err, rx_parity_err, rx_fifo_overflow, tx_fetch_valid;
    logic [5:0] ctl = 6'h0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, lfsr = 32'hED31, rdata;
    logic [FIELD_W-1:0] ta = 14'h0, tx_start_b = 14'h0, tx_end_a = 14'h0, tx_end_b = 14'h3FFF, tx_count = 14'h0;
    logic [FIELD_W-1:0] rx_end_a = 14'h3FFF, rx_count_a = 14'h0, rx_end_b = 14'h3FFF, rx_count_b = 14'h0;
    logic [FIELD_W-1:0] tx_fetch_addr;
    int n_fail = 0, samples_checked = 0;
    // free-running clock
    always #4 clk = ~clk;
    serial_dma_status #(.FIRST_CTRL(1'b1)) uut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .uart_mode,
        .spi_slave_mode, .slave_select_n, .tx_load_a(ctl[3]), .tx_load_b(ctl[4]), .tx_dma_reset(ctl[5]),
        .tx_start_b, .tx_end_a, .tx_end_b, .tx_count, .rx_load_a(ctl[0]), .rx_load_b(ctl[1]),
        .rx_dma_reset(ctl[2]), .rx_start_a(14'h0), .rx_start_b(14'h0), .rx_end_a, .rx_end_b,
        .rx_count_a, .rx_count_b, .rx_take, .rx_frame_err, .rx_parity_err, .rx_fifo_overflow,
        .tx_fetch_addr, .tx_fetch_valid);
    rx_fifo_model #(.DEPTH(4)) fifo (.clk, .nrst, .push, .push_fe, .push_pe, .drain_en, .rx_take,
        .rx_frame_err, .rx_parity_err, .rx_fifo_overflow);
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected status word from save code, error flags and in-use bits
    function automatic logic [31:0] stat_word(input logic [2:0] sv, input logic [5:0] er, input logic [3:0] act);
        return {19'h0, sv, er, act};
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bus cycles start just after an edge; read data sampled one edge later
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic expect_rd(input logic [31:0] a, input logic [31:0] e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(rdata, e);
    endtask
    task automatic pulse(input logic [5:0] m);
        ctl <= m;
        @(posedge clk);
        ctl <= 6'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic push_bytes(input int n, input logic fe, input logic pe);
        push <= 1'b1;
        push_fe <= fe;
        push_pe <= pe;
        repeat (n) @(posedge clk);
        push <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // select released, then room for the sync stages
    task automatic ssel_pulse;
        slave_select_n <= 1'b0;
        repeat (3) @(posedge clk);
        slave_select_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        expect_rd(TX_A_START_OFS, RAM_BASE);
        expect_rd(STATUS_OFS, STATUS_RST);
        // random start; status and near-miss writes must leave it alone
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            ta = {2'h0, lfsr[11:0]};
            reg_wr(TX_A_START_OFS, {lfsr[31:14], ta});
            expect_rd(TX_A_START_OFS, RAM_BASE | 32'(ta));
            reg_wr(STATUS_OFS, ~lfsr);
            // let an edge pass so the write strobe is never driven twice in one step
            @(posedge clk);
            reg_wr({lfsr[31:16] | 16'h8000, 16'hC810}, ~lfsr);
            expect_rd(STATUS_OFS, STATUS_RST);
            expect_rd({lfsr[31:8], 8'h04}, 32'h0);
        end
        expect_rd(TX_A_START_OFS, RAM_BASE | 32'(ta));
        // both tx buffers loaded: a first, b once a passes its end
        tx_end_a <= ta + 14'h10;
        tx_start_b <= {2'h0, lfsr[27:16]};
        pulse(TXA | TXB);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h4));
        check(32'(tx_fetch_addr), 32'(ta));
        check(32'(tx_fetch_valid), 32'h1);
        tx_count <= 14'h11;
        repeat (3) @(posedge clk);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h8));
        check(32'(tx_fetch_addr), 32'(tx_start_b + 14'h11));
        pulse(TXR);
        expect_rd(STATUS_OFS, STATUS_RST);
        // rx a: frame then parity marks, cleared by reloading a, ignored outside uart
        drain_en <= 1'b1;
        pulse(RXA);
        push_bytes(1, 1'b1, 1'b0);
        push_bytes(1, 1'b0, 1'b1);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h14, 4'h1));
        pulse(RXA);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h1));
        uart_mode <= 1'b0;
        push_bytes(2, 1'b1, 1'b1);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h1));
        // overflow with nothing loaded goes to b, the next to drain
        drain_en <= 1'b0;
        uart_mode <= 1'b1;
        pulse(RXR);
        push_bytes(5, 1'b0, 1'b0);
        pulse(RXB);
        drain_en <= 1'b1;
        repeat (8) @(posedge clk);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h02, 4'h2));
        pulse(RXB);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h2));
        // count save: a once, a again, b after a passes its end, cleared by a load
        uart_mode <= 1'b0;
        spi_slave_mode <= 1'b1;
        pulse(RXR);
        pulse(RXA | RXB);
        ssel_pulse();
        expect_rd(STATUS_OFS, stat_word(3'h2, 6'h0, 4'h1));
        ssel_pulse();
        expect_rd(STATUS_OFS, stat_word(3'h6, 6'h0, 4'h1));
        rx_end_a <= 14'h0;
        rx_count_a <= 14'h1;
        ssel_pulse();
        expect_rd(STATUS_OFS, stat_word(3'h7, 6'h0, 4'h2));
        pulse(RXA);
        expect_rd(STATUS_OFS, stat_word(3'h0, 6'h0, 4'h2));
        ssel_pulse();
        expect_rd(STATUS_OFS, stat_word(3'h3, 6'h0, 4'h2));
        // b runs past its end, pending a follows and is already past its own end
        rx_end_b <= 14'h0;
        rx_count_b <= 14'h1;
        repeat (3) @(posedge clk);
        expect_rd(STATUS_OFS, stat_word(3'h3, 6'h0, 4'h0));
        ctl <= RXR;
        @(posedge clk);
        ctl <= 6'h0;
        expect_rd(STATUS_OFS, STATUS_RST);
        end_of_test;
    end
endmodule // tb_top
